// [hw/ssw_pkg.sv]
// Shared constants and types for the select/watchdog pin logic
package ssw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;             // ref_clk rate
  localparam int unsigned HZ_PER_MS    = CLK_HZ / 1000;          // Cycles per millisecond
  localparam int unsigned HZ_PER_US    = CLK_HZ / 1_000_000;     // Cycles per microsecond
  localparam int unsigned POR_HOLD_MS  = 200;                    // Good-supply hold time
  localparam int unsigned POR_HOLD_CYC = POR_HOLD_MS * HZ_PER_MS;
  localparam int unsigned WRITE_US     = 5000;                   // Internal write cycle time
  localparam int unsigned WRITE_CYC    = WRITE_US * HZ_PER_US;
  localparam int unsigned WD_TMO0_MS   = 1000;                   // Watchdog period, code 0
  localparam int unsigned WD_TMO1_MS   = 500;                    // Watchdog period, code 1
  localparam int unsigned WD_TMO2_MS   = 250;                    // Watchdog period, code 2
  localparam int unsigned WD_TMO0_CYC  = WD_TMO0_MS * HZ_PER_MS;
  localparam int unsigned WD_TMO1_CYC  = WD_TMO1_MS * HZ_PER_MS;
  localparam int unsigned WD_TMO2_CYC  = WD_TMO2_MS * HZ_PER_MS;

  // ----------------------------------------------------------------
  // Encodings and field positions
  // ----------------------------------------------------------------
  localparam logic [1:0] WD_SEL_0   = 2'h0;  // Longest period
  localparam logic [1:0] WD_SEL_1   = 2'h1;
  localparam logic [1:0] WD_SEL_2   = 2'h2;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;  // Watchdog disabled
  localparam logic [2:0] BIT_FIRST  = 3'h0;  // Bit counter at byte start
  localparam logic [2:0] BIT_LAST   = 3'h7;  // Bit counter at eighth bit
  localparam logic [7:0] BYTE_RST   = 8'h00; // Shift register reset value
  localparam logic [31:0] CNT_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;  // One-cycle pulse per received byte
    logic [7:0] data;   // Byte, first bit received in bit 7
  } ssw_rx_s;

  typedef enum logic [1:0] {
    SUP_UV   = 2'b00,   // Supply low, reset held
    SUP_HOLD = 2'b01,   // Supply good, timing the hold
    SUP_RUN  = 2'b10    // Reset released
  } ssw_sup_e;

endpackage

// [hw/ssw_pin_logic.sv]
// Serial pin logic with select qualification, write protect and reset supervisor
`timescale 1ns/1ps

module ssw_pin_logic
  import ssw_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES   = POR_HOLD_CYC,  // Shorten in simulation
  parameter int unsigned WRITE_CYCLES      = WRITE_CYC,
  parameter int unsigned WD_CYCLES_0       = WD_TMO0_CYC,
  parameter int unsigned WD_CYCLES_1       = WD_TMO1_CYC,
  parameter int unsigned WD_CYCLES_2       = WD_TMO2_CYC,
  parameter bit          RESET_ACTIVE_HIGH = 1'b0          // Reset pin variant
) (
  input  wire logic       ref_clk,           // Core clock, 40 MHz
  input  wire logic       rst,               // Asynchronous, active high
  input  wire logic       sck,               // Serial clock from the host
  input  wire logic       select_and_kick_n, // Select and watchdog kick pin
  input  wire logic       si,                // Serial data in
  output logic            so_out,            // Serial data out
  output logic            so_oe,             // Serial data out enable
  input  wire logic       write_protect_n,   // Write protect pin
  input  wire logic       vcc_low,           // Supply monitor, high when low
  input  wire logic [1:0] wd_period_sel,     // Stored watchdog period bits
  input  wire logic [7:0] tx_byte,           // Next byte to shift out
  input  wire logic       tx_load,           // Latch tx_byte
  input  wire logic       nv_write_req,      // Current frame is a write
  output ssw_rx_s         rx,                // Received byte
  output logic            write_busy,        // Internal write cycle running
  output logic            nv_write_start,    // Pulse: internal write begins
  output logic            active_power,      // Device out of standby
  output logic            armed,             // First select fall seen
  output logic            reset_active,      // Supervisor reset asserted
  output logic            reset_pin_out,     // Open-drain data, always low
  output logic            reset_pin_oe       // Open-drain pull-down enable
);

  // ----------------------------------------------------------------
  // Link domain: shifting on the host serial clock
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt;   // Bits taken in the current byte
  logic [6:0] in_sh;     // Bits taken so far, first in the top
  logic [7:0] rx_hold;   // Last complete byte, stable for a byte time
  logic       rx_tog;    // Toggles once per complete byte
  logic [6:0] out_sh;    // Remaining bits of the outgoing byte
  logic [7:0] tx_hold;   // Core-side copy of the outgoing byte

  // Deselect clears the frame state; the clock may stop outside frames.
  // Using the pin as an asynchronous clear means a frame cut mid-byte
  // leaves no partial bits behind for the next frame.
  wire link_rst  = rst | select_and_kick_n;
  wire byte_done = (bit_cnt == BIT_LAST);
  wire byte_next = (bit_cnt == BIT_FIRST);

  // Capture on the rising edge, first bit lands highest
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= BIT_FIRST;
      in_sh   <= BYTE_RST[6:0];
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sh   <= {in_sh[5:0], si};
    end
  end

  // Hand the finished byte over; the toggle survives deselect.
  // rx_hold is read only after the toggle has crossed two flops, so the
  // host must leave a few core cycles between bytes for it to settle.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      rx_hold <= BYTE_RST;
      rx_tog  <= 1'b0;
    end else if (byte_done) begin
      rx_hold <= {in_sh, si};
      rx_tog  <= ~rx_tog;
    end
  end

  // Drive on the falling edge so the host samples on the next rise.
  // The first byte of a frame is the opcode, so nothing useful leaves
  // until the falling edge after the eighth rising edge.
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      so_out <= 1'b0;
      out_sh <= BYTE_RST[6:0];
    end else if (byte_next) begin
      so_out <= tx_hold[7];
      out_sh <= tx_hold[6:0];
    end else begin
      so_out <= out_sh[6];
      out_sh <= {out_sh[5:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers into the core domain
  // ----------------------------------------------------------------
  logic sel_s1, sel_s2, sel_d;   // Select pin, first stage read only by second
  logic wp_s1, wp_s2;            // Write protect pin
  logic uv_s1, uv_s2;            // Supply monitor
  logic tog_s1, tog_s2, tog_d;   // Byte toggle from the link

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_d  <= 1'b1;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
      uv_s1  <= 1'b1;
      uv_s2  <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_d  <= 1'b0;
    end else begin
      sel_s1 <= select_and_kick_n;
      sel_s2 <= sel_s1;
      sel_d  <= sel_s2;
      wp_s1  <= write_protect_n;
      wp_s2  <= wp_s1;
      uv_s1  <= vcc_low;
      uv_s2  <= uv_s1;
      tog_s1 <= rx_tog;
      tog_s2 <= tog_s1;
      tog_d  <= tog_s2;
    end
  end

  wire sel_fall  = sel_d & ~sel_s2;   // High-to-low on select
  wire sel_rise  = ~sel_d & sel_s2;   // End of a frame
  wire byte_evt  = tog_s2 ^ tog_d;    // A byte has completed
  wire selected  = ~sel_s2;

  // ----------------------------------------------------------------
  // Select qualification, data hand-off and output enable
  // ----------------------------------------------------------------
  // Power-up leaves the part unarmed until a select fall; the synchronisers reset high,
  // so a select already low at power-up is seen as a fall and arms it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (sel_fall) begin
      armed <= 1'b1;
    end
  end

  // Bytes before the first select fall are dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx <= '0;
    end else begin
      rx.valid <= byte_evt & armed;
      rx.data  <= byte_evt ? rx_hold : rx.data;
    end
  end

  // Held copy read by the falling-edge shifter; must settle before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_hold <= BYTE_RST;
    end else if (tx_load) begin
      tx_hold <= tx_byte;
    end
  end

  // Output floats whenever deselected or not yet qualified
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= selected & armed;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile write gating and internal write cycle
  // ----------------------------------------------------------------
  logic        wr_pend;   // A write frame is open and still allowed
  logic [31:0] wr_cnt;    // Cycles left in the internal write

  // Set needs protect high and select low; clear needs protect low or
  // select high, so set and clear never meet in one cycle.
  wire wr_set   = nv_write_req & armed & selected & wp_s2;
  wire wr_abort = ~wp_s2;
  wire wr_go    = sel_rise & wr_pend & wp_s2 & ~write_busy;
  wire wr_last  = (wr_cnt == 32'h0000_0001);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
    end else if (wr_set) begin
      wr_pend <= 1'b1;
    end else if (wr_abort || sel_rise) begin
      wr_pend <= 1'b0;
    end
  end

  // Once counting, protect is not looked at again
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_cnt         <= CNT_RST;
      write_busy     <= 1'b0;
      nv_write_start <= 1'b0;
    end else begin
      nv_write_start <= wr_go;
      if (wr_go) begin
        wr_cnt     <= WRITE_CYCLES;
        write_busy <= 1'b1;
      end else if (write_busy) begin
        wr_cnt     <= wr_cnt - 32'h0000_0001;
        write_busy <= ~wr_last;
      end
    end
  end

  // Standby only when deselected and no write is running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_power <= 1'b0;
    end else begin
      active_power <= selected | write_busy;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [31:0] wd_cnt;   // Cycles since the last select fall
  ssw_sup_e    sup;      // Supervisor state
  ssw_sup_e    next_sup;

  wire        wd_on    = (wd_period_sel != WD_SEL_OFF);
  wire [31:0] wd_limit = (wd_period_sel == WD_SEL_0) ? WD_CYCLES_0 :
                         (wd_period_sel == WD_SEL_1) ? WD_CYCLES_1 :
                         WD_CYCLES_2;
  wire        wd_hold  = (sup != SUP_RUN) | ~wd_on | sel_fall;
  wire        wd_exp   = wd_on & (sup == SUP_RUN) &
                         (wd_cnt >= wd_limit - 32'h0000_0001);

  // A stuck select, high or low, lets the count run out.
  // Counting from the synced edge adds two or three cycles to every
  // period, which is negligible against the real timeouts.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_cnt <= CNT_RST;
    end else if (wd_hold) begin
      wd_cnt <= CNT_RST;
    end else begin
      wd_cnt <= wd_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Reset supervisor
  // ----------------------------------------------------------------
  logic [31:0] hold_cnt;  // Cycles of continuous good supply

  wire hold_done = (hold_cnt >= POR_HOLD_CYCLES - 32'h0000_0001);

  // Any supply dip restarts the whole hold; watchdog reuses the hold.
  // Returning to the hold state rather than undervoltage gives a watchdog
  // reset the same length as a power-up reset.
  always_comb begin
    next_sup = sup;
    case (sup)
      SUP_UV: begin
        if (!uv_s2) begin
          next_sup = SUP_HOLD;
        end
      end
      SUP_HOLD: begin
        if (uv_s2) begin
          next_sup = SUP_UV;
        end else if (hold_done) begin
          next_sup = SUP_RUN;
        end
      end
      SUP_RUN: begin
        if (uv_s2) begin
          next_sup = SUP_UV;
        end else if (wd_exp) begin
          next_sup = SUP_HOLD;
        end
      end
      default: begin
        next_sup = SUP_UV;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sup <= SUP_UV;
    end else begin
      sup <= next_sup;
    end
  end

  // Hold count runs only in the hold state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= CNT_RST;
    end else if (sup == SUP_HOLD && next_sup == SUP_HOLD) begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
    end else begin
      hold_cnt <= CNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin
  // ----------------------------------------------------------------
  // Open drain can only pull low, so the high variant pulls while
  // released and lets the pull-up show the active level.
  // The data bit stays low so only the enable ever moves the pin.
  wire rst_next = (next_sup != SUP_RUN);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_active  <= 1'b1;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= ~RESET_ACTIVE_HIGH;
    end else begin
      reset_active  <= rst_next;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= RESET_ACTIVE_HIGH ? ~rst_next : rst_next;
    end
  end

endmodule

// [testbench/ssw_pin_logic_asserts.sv]
// Port-level checks for the select, write and reset supervisor logic
`timescale 1ns/1ps
module ssw_pin_logic_asserts
  import ssw_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES   = 50,
  parameter int unsigned WRITE_CYCLES      = 20,
  parameter int unsigned WD_CYCLES_0       = 300,
  parameter int unsigned WD_CYCLES_1       = 200,
  parameter int unsigned WD_CYCLES_2       = 100,
  parameter bit          RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       select_and_kick_n,
  input wire logic       vcc_low,
  input wire logic [1:0] wd_period_sel,
  input wire logic       so_oe,
  input wire ssw_rx_s    rx,
  input wire logic       write_busy,
  input wire logic       nv_write_start,
  input wire logic       active_power,
  input wire logic       armed,
  input wire logic       reset_active,
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [31:0] good_cnt; // Cycles of good supply in a row
  logic [31:0] busy_cnt; // Cycles of write busy in a row
  logic [31:0] wd_cnt;   // Cycles since the last select fall, pin side
  logic        sel_q;    // Select pin one edge ago
  logic [31:0] wd_lim;   // Period picked by the stored bits
  assign wd_lim = (wd_period_sel == WD_SEL_0) ? WD_CYCLES_0 :
                  (wd_period_sel == WD_SEL_1) ? WD_CYCLES_1 : WD_CYCLES_2;
  // Pin-side counting runs ahead of the synced logic, so bounds keep slack
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      good_cnt <= CNT_RST;
      busy_cnt <= CNT_RST;
      wd_cnt   <= CNT_RST;
      sel_q    <= 1'h1;
    end else begin
      good_cnt <= vcc_low ? CNT_RST : good_cnt + 32'h1;
      busy_cnt <= write_busy ? busy_cnt + 32'h1 : CNT_RST;
      wd_cnt   <= (reset_active || (sel_q && !select_and_kick_n)) ? CNT_RST : wd_cnt + 32'h1;
      sel_q    <= select_and_kick_n;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  uv_reset_a: assert property ($rose(vcc_low) |-> ##[1:3] reset_active)
    else $error("reset late after undervoltage");
  pin_drive_a: assert property (!reset_pin_out && (reset_pin_oe == (reset_active ^ RESET_ACTIVE_HIGH)))
    else $error("reset pin level wrong");
  hold_time_a: assert property ($fell(reset_active) |-> good_cnt >= POR_HOLD_CYCLES)
    else $error("reset released early");
  wd_early_a: assert property ($rose(reset_active) && !vcc_low && !$past(vcc_low) && !$past(vcc_low, 3)
    |-> wd_period_sel != WD_SEL_OFF && wd_cnt + 32'h2 >= wd_lim)
    else $error("watchdog fired early");
  wd_late_a: assert property (wd_period_sel != WD_SEL_OFF && !vcc_low && wd_cnt == wd_lim + 32'h8
    |-> reset_active)
    else $error("watchdog did not fire");
  busy_len_a: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYCLES)
    else $error("write cycle length wrong");
  write_begin_a: assert property (nv_write_start |-> write_busy && !$past(write_busy) && select_and_kick_n)
    else $error("write started out of turn");
  desel_hiz_a: assert property (select_and_kick_n [*4] |-> !so_oe)
    else $error("output driven while deselected");
  sel_active_a: assert property (!select_and_kick_n [*4] |-> active_power)
    else $error("not active while selected");
  standby_a: assert property ((select_and_kick_n && !write_busy) [*5] |-> !active_power)
    else $error("no standby while idle");
  arm_first_a: assert property (so_oe |-> armed)
    else $error("driving before first select fall");
  rx_pulse_a: assert property (rx.valid |-> armed ##1 !rx.valid)
    else $error("received byte pulse wrong");
  cover property ($fell(write_busy));
  cover property ($fell(reset_active));
  cover property (rx.valid);
endmodule

// [testbench/ssw_host_model.sv]
// Host serial master model driving select, clock and data
`timescale 1ns/1ps
module ssw_host_model (
  output logic      sck,               // Serial clock, still outside frames
  output logic      select_and_kick_n, // Select and watchdog kick
  output logic      si,                // Data to the device
  input  wire logic so_out,            // Data from the device
  input  wire logic so_oe              // Device drives the data line
);
  logic last_so; // Last level the device drove
  logic so_pin;  // Level on the line; no pull, so undriven shows the inverse
  initial begin
    sck = 1'h0;
    select_and_kick_n = 1'h1;
    si = 1'h0;
    last_so = 1'h0;
  end
  always @(so_out or so_oe) if (so_oe) last_so = so_out;
  assign so_pin = so_oe ? so_out : ~last_so;
  // One frame of two bytes, clock paused between them
  task automatic frame(input logic [15:0] mosi, output logic [15:0] miso);
    #2 select_and_kick_n = 1'h0;
    #125;
    for (int i = 15; i >= 0; i--) begin
      si = mosi[i];
      #3 sck = 1'h1;
      miso[i] = so_pin;
      #3 sck = 1'h0;
      if (i == 8) #150;
    end
    #3 si = ~si;
    select_and_kick_n = 1'h1;
    #100;
  endtask
endmodule

// [testbench/spi_select_watchdog_pin_logic_tb.sv]
// Self-checking bench for the select, write and reset supervisor logic
`timescale 1ns/1ps
module spi_select_watchdog_pin_logic_tb;
  import ssw_pkg::*;
  localparam int unsigned HOLD = 50;
  localparam int unsigned WR   = 20;
  logic        ref_clk = 1'h0, rst = 1'h1, write_protect_n = 1'h1, vcc_low = 1'h1;
  logic        tx_load = 1'h0, nv_write_req = 1'h0;
  logic [1:0]  wd_period_sel = WD_SEL_OFF;
  logic [7:0]  tx_byte = 8'h00;
  logic        sck, select_and_kick_n, si, so_out, so_oe, write_busy, nv_write_start;
  logic        active_power, armed, reset_active, reset_pin_out, reset_pin_oe;
  ssw_rx_s     rx;
  int          failures = 0, n_tests = 0, cyc = 0, t_fall, n;
  int unsigned lim[3] = '{300, 200, 100};
  logic [15:0] starts = 16'h0, miso;
  logic [31:0] seed = 32'h2d31b64d;
  logic [7:0]  exp_q[$];
  always #12.5 ref_clk = ~ref_clk;
  ssw_pin_logic #(.POR_HOLD_CYCLES(HOLD), .WRITE_CYCLES(WR), .WD_CYCLES_0(300), .WD_CYCLES_1(200),
    .WD_CYCLES_2(100)) u_dut (.ref_clk(ref_clk), .rst(rst), .sck(sck), .select_and_kick_n(select_and_kick_n),
    .si(si), .so_out(so_out), .so_oe(so_oe), .write_protect_n(write_protect_n), .vcc_low(vcc_low),
    .wd_period_sel(wd_period_sel), .tx_byte(tx_byte), .tx_load(tx_load), .nv_write_req(nv_write_req),
    .rx(rx), .write_busy(write_busy), .nv_write_start(nv_write_start), .active_power(active_power),
    .armed(armed), .reset_active(reset_active), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));
  ssw_host_model u_host (.sck(sck), .select_and_kick_n(select_and_kick_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_rst(input logic lvl, input int lim_n);
    n = 0;
    while (reset_active !== lvl && n < lim_n) begin
      step(1);
      n++;
    end
  endtask
  // One frame: two random bytes in, the loaded byte read back second
  task automatic xfer(input logic wr, input logic wp, input logic drop);
    logic [31:0] r;
    r = rnd();
    step(1);
    tx_byte = r[23:16];
    tx_load = 1'h1;
    write_protect_n = wp;
    nv_write_req = wr;
    step(1);
    tx_load = 1'h0;
    exp_q.push_back(r[15:8]);
    exp_q.push_back(r[7:0]);
    t_fall = cyc;
    fork
      u_host.frame(r[15:0], miso);
      if (drop) #300 write_protect_n = 1'h0;
    join
    step(2);
    nv_write_req = 1'h0;
    check("so first byte", miso[15:8], 16'h0);
    check("so second byte", miso[7:0], r[23:16]);
  endtask
  // ----------------------------------------------------------------
  // Monitors: received bytes against the queue, write starts, timeout
  // ----------------------------------------------------------------
  // Sample on the falling edge so registered outputs have settled
  always @(negedge ref_clk) begin
    if (rx.valid === 1'h1) begin
      if (exp_q.size() == 0) check("rx extra", 16'h1, 16'h0);
      else check("rx data", rx.data, exp_q.pop_front());
    end
    if (nv_write_start === 1'h1) starts <= starts + 16'h1;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(20);
    rst = 1'h0;
    check("reset_active", reset_active, 16'h1);
    check("reset_pin_oe", reset_pin_oe, 16'h1);
    check("armed", armed, 16'h0);
    vcc_low = 1'h0;
    wait_rst(1'h0, 200);
    check("hold", n >= HOLD && n <= HOLD + 6, 16'h1);
    $display("power-up test done");
    for (int k = 0; k < 4; k++) xfer(1'h0, 1'h1, 1'h0);
    check("so_oe idle", so_oe, 16'h0);
    check("standby", active_power, 16'h0);
    $display("transfer test done");
    xfer(1'h1, 1'h1, 1'h0);
    check("busy", write_busy, 16'h1);
    check("awake while busy", active_power, 16'h1);
    write_protect_n = 1'h0;
    n = 0;
    while (write_busy === 1'h1 && n < 40) begin
      step(1);
      n++;
    end
    check("busy ends", n >= WR - 8 && n < WR, 16'h1);
    xfer(1'h1, 1'h0, 1'h0);
    step(6);
    check("starts", starts, 16'h1);
    xfer(1'h1, 1'h1, 1'h1);
    step(6);
    check("starts", starts, 16'h1);
    write_protect_n = 1'h1;
    $display("write test done");
    wd_period_sel = WD_SEL_2;
    for (int k = 0; k < 5; k++) begin
      xfer(1'h0, 1'h1, 1'h0);
      step(60);
    end
    check("kicked", reset_active, 16'h0);
    for (int k = 0; k < 3; k++) begin
      wd_period_sel = k[1:0];
      xfer(1'h0, 1'h1, 1'h0);
      wait_rst(1'h1, 400);
      check("wd time", cyc - t_fall >= lim[k] && cyc - t_fall <= lim[k] + 8, 16'h1);
      wait_rst(1'h0, 100);
    end
    wd_period_sel = WD_SEL_OFF;
    xfer(1'h0, 1'h1, 1'h0);
    step(400);
    check("wd off", reset_active, 16'h0);
    $display("watchdog test done");
    vcc_low = 1'h1;
    step(4);
    check("brownout", reset_active, 16'h1);
    vcc_low = 1'h0;
    wait_rst(1'h0, 100);
    check("rx left", 16'(exp_q.size()), 16'h0);
    $display("brownout test done");
    conclude();
  end
endmodule
bind ssw_pin_logic ssw_pin_logic_asserts #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES), .WRITE_CYCLES(WRITE_CYCLES),
  .WD_CYCLES_0(WD_CYCLES_0), .WD_CYCLES_1(WD_CYCLES_1), .WD_CYCLES_2(WD_CYCLES_2),
  .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .select_and_kick_n(select_and_kick_n), .vcc_low(vcc_low), .wd_period_sel(wd_period_sel), .so_oe(so_oe),
  .rx(rx), .write_busy(write_busy), .nv_write_start(nv_write_start), .active_power(active_power),
  .armed(armed), .reset_active(reset_active), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));
